// ---- rtl/safing_params.svh ----
// constants of the spi snooping safing engine
// assumes a 20 MHz system clock and a free bus clock only inside frames
// Overview of operation
// R1 - four independent safing records, each watching one sensor
// R2 - request and response recognised by mask and target compares
// R3 - sensor data is data mask ANDed with the sensor word
// R4 - masked data right-justified to 16 bits, treated as signed
// R5 - each record holds a threshold limiting its sensor data
// R6 - in-frame flag picks same or next transfer for the answer
// R7 - chip-select field binds record to one of two monitored selects
// R8 - each record maps to either arming signal, several may share one
// R9 - arming stays asserted for the record's dwell once detected
// R10 - limit enable checks range, limit select picks 8 or 10 bits
// R11 - 32-bit messages: field select picks bits 0-15 or 16-31
// R12 - shorter messages always use the first 16 received bits
// R13 - one packet matching several records feeds each independently
// R14 - only first match evaluated, sets compare complete until cleared
// R15 - record enable changes apply from the next sampling period
// R16 - all compare complete flags gathered in one readable word
// R17 - sensor data processed only in the safing state
// R18 - safing state machine reset clears all record contents
// R19 - combine only for record pairs one-two and three-four
// R20 - combined arithmetic only after both inputs are captured
// R21 - pair sum checks record n threshold, difference record n+1
// R22 - arming signals routable to any deployment channel
// R23 - event counters add on exceed, otherwise subtract
// R24 - counters compared with arm thresholds give arming results
// R25 - arming signal is OR of enabled records mapped to it; a running dwell asserts it even for a disabled record
// R26 - dwell only extended, loaded when above the remaining time
// R27 - bits sampled on bus clock, matched when select deasserts
`ifndef SAFING_PARAMS_SVH
`define SAFING_PARAMS_SVH
`define REC_NUM 4
`define WORD_BITS 32
`define FIELD_BITS 16
`define HI_FIELD_LSB 16
`define LIM8_MSB 7
`define LIM10_MSB 9
`define CLK_PERIOD_NS 50
`define DWELL_TICK_US 1000
`define DWELL_TICK_CYCLES (`DWELL_TICK_US * 1000 / `CLK_PERIOD_NS)
`endif

// ---- rtl/safing_pkg.sv ----
// types shared by the safing engine
// assumes safing_params.svh holds the numbers
package safing_pkg;
  typedef logic [31:0] word_t;
  typedef logic [15:0] field_t;
  typedef logic signed [16:0] value_t;
  typedef logic [7:0] count_t;
  typedef logic [5:0] len_t;
endpackage

// ---- rtl/spi_snooping_safing_engine.sv ----
// passive spi monitor feeding four safing records and two arming signals
// assumes cs inputs are active low and frames are separated by a gap
`timescale 1ns/10ps
`include "safing_params.svh"
module spi_snooping_safing_engine #(
  parameter int DWELL_TICK_CYCLES = `DWELL_TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic spi_clock_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic monitor_select_zero_n_i,
  input wire logic monitor_select_one_n_i,
  input wire logic safing_state_i,
  input wire logic safing_fsm_reset_i,
  input wire logic [3:0] record_enable_i,
  input wire logic [3:0][31:0] request_mask_i,
  input wire logic [3:0][31:0] request_target_i,
  input wire logic [3:0][31:0] response_mask_i,
  input wire logic [3:0][31:0] response_target_i,
  input wire logic [3:0][15:0] record_data_mask_i,
  input wire logic [3:0][15:0] record_threshold_i,
  input wire logic [3:0] in_frame_i,
  input wire logic [3:0] chip_select_i,
  input wire logic [3:0] arm_select_i,
  input wire logic [3:0][7:0] dwell_i,
  input wire logic [3:0] combine_i,
  input wire logic [3:0] limit_enable_i,
  input wire logic [3:0] limit_select_i,
  input wire logic [3:0] field_select_i,
  input wire logic [7:0] counter_increment_i,
  input wire logic [7:0] counter_decrement_i,
  input wire logic [7:0] positive_arm_threshold_i,
  input wire logic [7:0] negative_arm_threshold_i,
  input wire logic [3:0] compare_complete_clear_i,
  input wire logic [3:0] loop_mask_one_i,
  input wire logic [3:0] loop_mask_two_i,
  output logic [3:0] compare_complete_flags_o,
  output logic arm_signal_one_o,
  output logic arm_signal_two_o,
  output logic [3:0] channel_arm_o
);

  // ==========================================================
  // functions
  function automatic safing_pkg::word_t align_word(input safing_pkg::word_t sh, input safing_pkg::len_t len);
    if (len >= 6'd32) begin
      return sh;
    end
    return sh >> (6'd32 - len);
  endfunction

  function automatic safing_pkg::field_t pick_field(input safing_pkg::word_t w, input safing_pkg::len_t len,
                                                   input logic fs);
    if (len >= 6'd32 && fs) begin // [R11]
      return w[`HI_FIELD_LSB +: `FIELD_BITS];
    end
    return w[`FIELD_BITS-1:0]; // [R11] [R12]
  endfunction

  function automatic safing_pkg::field_t right_justify(input safing_pkg::field_t v, input safing_pkg::field_t m);
    safing_pkg::field_t r;
    logic [4:0] j;
    r = '0;
    j = '0;
    for (int k = 0; k < `FIELD_BITS; k++) begin
      if (m[k]) begin
        r[j[3:0]] = v[k];
        j = j + 5'h01;
      end
    end
    return r;
  endfunction

  function automatic logic in_range(input safing_pkg::field_t v, input logic sel);
    if (sel) begin
      return (&v[15:`LIM10_MSB]) | ~(|v[15:`LIM10_MSB]);
    end
    return (&v[15:`LIM8_MSB]) | ~(|v[15:`LIM8_MSB]);
  endfunction

  function automatic safing_pkg::count_t sat_add(input safing_pkg::count_t a, input safing_pkg::count_t b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8] ? 8'hFF : s[7:0];
  endfunction

  function automatic safing_pkg::count_t sat_sub(input safing_pkg::count_t a, input safing_pkg::count_t b);
    return (a > b) ? a - b : 8'h00;
  endfunction

  // ==========================================================
  // link domain: shift in both lines while a select is low
  logic frame_act;
  logic link_rst_n;
  safing_pkg::word_t mosi_sh_q;
  safing_pkg::word_t miso_sh_q;
  safing_pkg::len_t len_q;
  safing_pkg::len_t len_d;
  safing_pkg::word_t hold_mosi_q;
  safing_pkg::word_t hold_miso_q;
  safing_pkg::len_t hold_len_q;

  assign frame_act = ~(monitor_select_zero_n_i & monitor_select_one_n_i);
  assign link_rst_n = resetn_i & frame_act;
  assign len_d = (len_q == 6'h3F) ? len_q : len_q + 6'h01;

  // first received bit ends up at bit 0
  always_ff @(posedge spi_clock_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      mosi_sh_q <= '0;
      miso_sh_q <= '0;
      len_q <= '0;
    end else begin
      mosi_sh_q <= {mosi_i, mosi_sh_q[31:1]}; // [R27]
      miso_sh_q <= {miso_i, miso_sh_q[31:1]};
      len_q <= len_d;
    end
  end

  // copy that outlives the frame, quiet through the inter-frame gap
  always_ff @(posedge spi_clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_mosi_q <= '0;
      hold_miso_q <= '0;
      hold_len_q <= '0;
    end else begin
      hold_mosi_q <= {mosi_i, mosi_sh_q[31:1]};
      hold_miso_q <= {miso_i, miso_sh_q[31:1]};
      hold_len_q <= len_d;
    end
  end

  // ==========================================================
  // select synchronisers and frame end detection
  logic cs0_m_q;
  logic cs0_s_q;
  logic cs1_m_q;
  logic cs1_s_q;
  logic act_q;
  logic last_cs_q;
  logic fe_q;
  safing_pkg::word_t mosi_w_q;
  safing_pkg::word_t miso_w_q;
  safing_pkg::len_t len_w_q;
  logic cs_w_q;
  logic frame_end;

  assign frame_end = act_q & cs0_s_q & cs1_s_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs0_m_q <= 1'b1;
      cs0_s_q <= 1'b1;
      cs1_m_q <= 1'b1;
      cs1_s_q <= 1'b1;
      act_q <= 1'b0;
      last_cs_q <= 1'b0;
    end else begin
      cs0_m_q <= monitor_select_zero_n_i;
      cs0_s_q <= cs0_m_q;
      cs1_m_q <= monitor_select_one_n_i;
      cs1_s_q <= cs1_m_q;
      act_q <= ~(cs0_s_q & cs1_s_q);
      if (!cs1_s_q) begin
        last_cs_q <= 1'b1;
      end else if (!cs0_s_q) begin
        last_cs_q <= 1'b0;
      end
    end
  end

  // words taken once the deasserted select has crossed over
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fe_q <= 1'b0;
      mosi_w_q <= '0;
      miso_w_q <= '0;
      len_w_q <= '0;
      cs_w_q <= 1'b0;
    end else begin
      fe_q <= frame_end; // [R27]
      if (frame_end) begin
        mosi_w_q <= align_word(hold_mosi_q, hold_len_q);
        miso_w_q <= align_word(hold_miso_q, hold_len_q);
        len_w_q <= hold_len_q;
        cs_w_q <= last_cs_q;
      end
    end
  end

  // ==========================================================
  // record matching
  logic proc_ok;
  logic [3:0] cs_ok;
  logic [3:0] req_hit;
  logic [3:0] hit;
  logic [3:0] lim_ok;
  safing_pkg::field_t raw [4];
  logic [3:0] en_q;
  logic [3:0] pend_q;
  logic [3:0] cc_q;

  assign proc_ok = fe_q & safing_state_i & ~safing_fsm_reset_i; // [R17]

  always_comb begin
    for (int i = 0; i < `REC_NUM; i++) begin // [R1] [R13]
      cs_ok[i] = chip_select_i[i] == cs_w_q; // [R7]
      req_hit[i] = (mosi_w_q & request_mask_i[i]) == request_target_i[i]; // [R2]
      raw[i] = right_justify(pick_field(miso_w_q, len_w_q, field_select_i[i]) & record_data_mask_i[i],
                             record_data_mask_i[i]); // [R3] [R4]
      lim_ok[i] = ~limit_enable_i[i] | in_range(raw[i], limit_select_i[i]); // [R10]
      hit[i] = proc_ok & cs_ok[i] & en_q[i] & ~cc_q[i]
             & ((miso_w_q & response_mask_i[i]) == response_target_i[i]) // [R2]
             & (in_frame_i[i] ? req_hit[i] : pend_q[i]); // [R6] [R14]
    end
  end

  // ==========================================================
  // record state
  logic [3:0] cap_q;
  logic [3:0] done_q;
  safing_pkg::field_t data_q [4];
  logic [3:0] clr;
  logic [3:0] ready;
  safing_pkg::value_t val [4];
  logic [3:0] exc_p;
  logic [3:0] exc_n;

  assign clr = compare_complete_clear_i & ~hit;

  always_comb begin
    for (int i = 0; i < `REC_NUM; i++) begin
      ready[i] = safing_state_i & cap_q[i] & ~done_q[i] & (~combine_i[i] | cap_q[i ^ 1]); // [R19] [R20]
      if (!combine_i[i]) begin
        val[i] = {data_q[i][15], data_q[i]};
      end else if (i % 2 == 0) begin
        val[i] = $signed({data_q[i][15], data_q[i]}) + $signed({data_q[i ^ 1][15], data_q[i ^ 1]}); // [R21]
      end else begin
        val[i] = $signed({data_q[i][15], data_q[i]}) - $signed({data_q[i ^ 1][15], data_q[i ^ 1]}); // [R21]
      end
      exc_p[i] = val[i] > $signed({1'b0, record_threshold_i[i]}); // [R5]
      exc_n[i] = val[i] < -$signed({1'b0, record_threshold_i[i]}); // [R5]
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_q <= '0;
      pend_q <= '0;
      cap_q <= '0;
      done_q <= '0;
      cc_q <= '0;
      data_q <= '{default: '0};
    end else if (safing_fsm_reset_i) begin
      en_q <= '0; // [R18]
      pend_q <= '0;
      cap_q <= '0;
      done_q <= '0;
      cc_q <= '0;
      data_q <= '{default: '0};
    end else begin
      if (fe_q) begin
        en_q <= record_enable_i; // [R15]
      end
      for (int i = 0; i < `REC_NUM; i++) begin
        if (proc_ok && cs_ok[i]) begin
          pend_q[i] <= req_hit[i]; // [R6]
        end
        cc_q[i] <= hit[i] | (cc_q[i] & ~clr[i]); // [R14] [R16]
        if (hit[i] && lim_ok[i]) begin
          cap_q[i] <= 1'b1;
          data_q[i] <= raw[i];
        end else if (clr[i]) begin
          cap_q[i] <= 1'b0;
        end
        if (clr[i]) begin
          done_q[i] <= 1'b0;
        end else if (ready[i]) begin
          done_q[i] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // event counters and arming results
  safing_pkg::count_t pos_q [4];
  safing_pkg::count_t neg_q [4];
  logic [3:0] armp_q;
  logic [3:0] armn_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_q <= '{default: '0};
      neg_q <= '{default: '0};
      armp_q <= '0;
      armn_q <= '0;
    end else if (safing_fsm_reset_i) begin
      pos_q <= '{default: '0};
      neg_q <= '{default: '0};
      armp_q <= '0;
      armn_q <= '0;
    end else begin
      for (int i = 0; i < `REC_NUM; i++) begin
        if (ready[i]) begin
          pos_q[i] <= exc_p[i] ? sat_add(pos_q[i], counter_increment_i)
                               : sat_sub(pos_q[i], counter_decrement_i); // [R23]
          neg_q[i] <= exc_n[i] ? sat_add(neg_q[i], counter_increment_i)
                               : sat_sub(neg_q[i], counter_decrement_i); // [R23]
        end
        armp_q[i] <= safing_state_i & (pos_q[i] >= positive_arm_threshold_i); // [R24]
        armn_q[i] <= safing_state_i & (neg_q[i] >= negative_arm_threshold_i); // [R24]
      end
    end
  end

  // ==========================================================
  // dwell stretch
  logic [15:0] tick_q;
  logic tick;
  safing_pkg::count_t dwell_q [4];

  assign tick = tick_q == 16'(DWELL_TICK_CYCLES - 1);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dwell_q <= '{default: '0};
    end else if (safing_fsm_reset_i) begin
      dwell_q <= '{default: '0};
    end else begin
      for (int i = 0; i < `REC_NUM; i++) begin
        if ((armp_q[i] | armn_q[i]) && dwell_i[i] > dwell_q[i]) begin
          dwell_q[i] <= dwell_i[i]; // [R9] [R26]
        end else if (tick && dwell_q[i] != 8'h00) begin
          dwell_q[i] <= dwell_q[i] - 8'h01; // [R9]
        end
      end
    end
  end

  // ==========================================================
  // arming outputs
  logic [3:0] rec_arm;
  logic arm1_d;
  logic arm2_d;

  always_comb begin
    arm1_d = 1'b0;
    arm2_d = 1'b0;
    for (int i = 0; i < `REC_NUM; i++) begin
      rec_arm[i] = (en_q[i] & (armp_q[i] | armn_q[i])) | (dwell_q[i] != 8'h00); // [R9]
      arm1_d = arm1_d | (rec_arm[i] & ~arm_select_i[i]); // [R8] [R25]
      arm2_d = arm2_d | (rec_arm[i] & arm_select_i[i]); // [R8] [R25]
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arm_signal_one_o <= 1'b0;
      arm_signal_two_o <= 1'b0;
      channel_arm_o <= '0;
    end else if (safing_fsm_reset_i) begin
      arm_signal_one_o <= 1'b0; // [R18]
      arm_signal_two_o <= 1'b0;
      channel_arm_o <= '0;
    end else begin
      arm_signal_one_o <= arm1_d;
      arm_signal_two_o <= arm2_d;
      channel_arm_o <= ({4{arm1_d}} & loop_mask_one_i) | ({4{arm2_d}} & loop_mask_two_i); // [R22]
    end
  end

  assign compare_complete_flags_o = cc_q; // [R16]

endmodule

// ---- sim/safing_engine_properties.sv ----
// assertions on the safing engine ports
// assumes binding onto spi_snooping_safing_engine, all checks on clock_i
`timescale 1ns/10ps
module safing_engine_properties #(
  parameter int DWELL_TICK_CYCLES = 20000
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic monitor_select_zero_n_i,
  input wire logic monitor_select_one_n_i,
  input wire logic safing_state_i,
  input wire logic safing_fsm_reset_i,
  input wire logic [3:0][7:0] dwell_i,
  input wire logic [7:0] positive_arm_threshold_i,
  input wire logic [7:0] negative_arm_threshold_i,
  input wire logic [3:0] compare_complete_clear_i,
  input wire logic [3:0] loop_mask_one_i,
  input wire logic [3:0] loop_mask_two_i,
  input wire logic [3:0] compare_complete_flags_o,
  input wire logic arm_signal_one_o,
  input wire logic arm_signal_two_o,
  input wire logic [3:0] channel_arm_o
);
  logic [3:0] since_q;
  logic [3:0] off_q;
  // ====
  // cycles since both selects idle, cycles out of safing state
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      since_q <= 4'h0;
    end else if (!monitor_select_zero_n_i || !monitor_select_one_n_i) begin
      since_q <= 4'h0;
    end else if (since_q != 4'hF) begin
      since_q <= since_q + 4'h1;
    end
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      off_q <= 4'h0;
    end else if (safing_state_i) begin
      off_q <= 4'h0;
    end else if (off_q != 4'hF) begin
      off_q <= off_q + 4'h1;
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_new_flag;
    (compare_complete_flags_o & ~$past(compare_complete_flags_o)) != 4'h0;
  endsequence
  sequence s_frame_done;
    since_q >= 4'h2 && since_q <= 4'h9;
  endsequence
  a_quiet_after_reset: assert property ($rose(resetn_i) |-> compare_complete_flags_o == 4'h0 && !arm_signal_one_o && !arm_signal_two_o) else $error("outputs active after reset");
  a_fsm_reset_clears: assert property (safing_fsm_reset_i |=> compare_complete_flags_o == 4'h0 && !arm_signal_one_o && !arm_signal_two_o) else $error("safing reset left state");
  a_flag_after_frame: assert property (s_new_flag |-> s_frame_done) else $error("flag set outside frame end");
  a_flag_stays_set: assert property (!safing_fsm_reset_i |=> (($past(compare_complete_flags_o) & ~$past(compare_complete_clear_i)) & ~compare_complete_flags_o) == 4'h0) else $error("flag dropped");
  a_flag_clear_works: assert property (compare_complete_clear_i != 4'h0 && since_q == 4'hF |=> (compare_complete_flags_o & $past(compare_complete_clear_i)) == 4'h0) else $error("flag not cleared");
  a_safing_state_gate: assert property (s_new_flag |-> off_q < 4'h4) else $error("frame processed outside safing state");
  a_channel_route: assert property (channel_arm_o == (({4{arm_signal_one_o}} & $past(loop_mask_one_i)) | ({4{arm_signal_two_o}} & $past(loop_mask_two_i)))) else $error("channel routing wrong");
  a_arm_after_frame: assert property ($rose(arm_signal_one_o) && positive_arm_threshold_i != 8'h00 && negative_arm_threshold_i != 8'h00 |-> since_q >= 4'h4 && since_q <= 4'hB) else $error("arming without a frame");
  a_arm_dwell_hold: assert property (disable iff (!resetn_i || safing_fsm_reset_i) $rose(arm_signal_one_o) && dwell_i[0] > 8'h01 && dwell_i[1] > 8'h01 && dwell_i[2] > 8'h01 && dwell_i[3] > 8'h01 |=> arm_signal_one_o [*2]) else $error("arming shorter than dwell");
endmodule
bind spi_snooping_safing_engine safing_engine_properties #(.DWELL_TICK_CYCLES(DWELL_TICK_CYCLES)) i_props (
  .clock_i, .resetn_i, .monitor_select_zero_n_i, .monitor_select_one_n_i, .safing_state_i,
  .safing_fsm_reset_i, .dwell_i, .positive_arm_threshold_i, .negative_arm_threshold_i,
  .compare_complete_clear_i, .loop_mask_one_i, .loop_mask_two_i, .compare_complete_flags_o,
  .arm_signal_one_o, .arm_signal_two_o, .channel_arm_o);

// ---- sim/spi_bus_model.sv ----
// host and sensors sharing the monitored spi bus
// assumes the engine only listens; bit 0 of each word goes out first
`timescale 1ns/10ps
module spi_bus_model (
  output logic spi_clock_o,
  output logic mosi_o,
  output logic miso_o,
  output logic select_zero_n_o,
  output logic select_one_n_o
);
  initial begin
    spi_clock_o = 1'b0;
    mosi_o = 1'b0;
    miso_o = 1'b1;
    select_zero_n_o = 1'b1;
    select_one_n_o = 1'b1;
  end
  // ====
  // one frame of up to 32 bits, 64 ns bus clock only inside it
  task automatic frame(input logic cs, input logic [31:0] req, input logic [31:0] rsp, input int bits);
    #13;
    select_zero_n_o = cs;
    select_one_n_o = ~cs;
    for (int b = 0; b < bits; b++) begin
      mosi_o = req[b];
      miso_o = rsp[b];
      #32 spi_clock_o = 1'b1;
      #32 spi_clock_o = 1'b0;
    end
    #32 select_zero_n_o = 1'b1;
    select_one_n_o = 1'b1;
    mosi_o = ~mosi_o;
    miso_o = ~miso_o;
    #600;
  endtask
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the spi snooping safing engine
// assumes spi_bus_model plays host and sensors; checker is bound
`timescale 1ns/10ps
module tb;
  logic clock_i, resetn_i, safing_state_i, safing_fsm_reset_i;
  logic spi_clock_i, mosi_i, miso_i, monitor_select_zero_n_i, monitor_select_one_n_i;
  logic [3:0] record_enable_i, in_frame_i, chip_select_i, arm_select_i, combine_i;
  logic [3:0] limit_enable_i, limit_select_i, field_select_i, compare_complete_clear_i;
  logic [3:0] loop_mask_one_i, loop_mask_two_i, compare_complete_flags_o, channel_arm_o;
  logic [3:0][31:0] request_mask_i, request_target_i, response_mask_i, response_target_i;
  logic [3:0][15:0] record_data_mask_i, record_threshold_i;
  logic [3:0][7:0] dwell_i;
  logic [7:0] counter_increment_i, counter_decrement_i, positive_arm_threshold_i, negative_arm_threshold_i;
  logic arm_signal_one_o, arm_signal_two_o;
  int miscompares;
  int checked;
  int frame_bits = 32;
  // ====
  // design and bus partner
  spi_snooping_safing_engine #(.DWELL_TICK_CYCLES(4)) i_dut (
    .clock_i, .resetn_i, .spi_clock_i, .mosi_i, .miso_i, .monitor_select_zero_n_i,
    .monitor_select_one_n_i, .safing_state_i, .safing_fsm_reset_i, .record_enable_i,
    .request_mask_i, .request_target_i, .response_mask_i, .response_target_i,
    .record_data_mask_i, .record_threshold_i, .in_frame_i, .chip_select_i, .arm_select_i,
    .dwell_i, .combine_i, .limit_enable_i, .limit_select_i, .field_select_i,
    .counter_increment_i, .counter_decrement_i, .positive_arm_threshold_i,
    .negative_arm_threshold_i, .compare_complete_clear_i, .loop_mask_one_i, .loop_mask_two_i,
    .compare_complete_flags_o, .arm_signal_one_o, .arm_signal_two_o, .channel_arm_o);
  spi_bus_model i_bus (.spi_clock_o(spi_clock_i), .mosi_o(mosi_i), .miso_o(miso_i),
    .select_zero_n_o(monitor_select_zero_n_i), .select_one_n_o(monitor_select_one_n_i));
  // ====
  // helpers
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("%0d comparisons, %0d mismatches", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic send(input logic cs, input logic [31:0] req, input logic [31:0] rsp);
    i_bus.frame(cs, req, rsp, frame_bits);
    wait_cycles(14);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  // ====
  // tests
  initial begin
    resetn_i <= 1'b0;
    safing_state_i <= 1'b1;
    safing_fsm_reset_i <= 1'b0;
    record_enable_i <= 4'h7;
    in_frame_i <= 4'hF;
    chip_select_i <= 4'h2;
    arm_select_i <= 4'h4;
    field_select_i <= 4'h4;
    combine_i <= 4'h0;
    limit_enable_i <= 4'h0;
    limit_select_i <= 4'h0;
    compare_complete_clear_i <= 4'h0;
    loop_mask_one_i <= 4'h5;
    loop_mask_two_i <= 4'hA;
    counter_increment_i <= 8'h01;
    counter_decrement_i <= 8'h01;
    positive_arm_threshold_i <= 8'h01;
    negative_arm_threshold_i <= 8'h01;
    for (int r = 0; r < 4; r++) begin
      request_mask_i[r] <= 32'h0000_00FF;
      request_target_i[r] <= 32'h0000_00A5;
      response_mask_i[r] <= 32'hFF00_0000;
      response_target_i[r] <= 32'h3C00_0000;
      record_data_mask_i[r] <= (r == 3) ? 16'hFFFF : 16'h00FF;
      record_threshold_i[r] <= 16'h0030;
      dwell_i[r] <= 8'h02;
    end
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    wait_cycles(4);
    send(1'b1, 32'h0000_0000, 32'h0000_0000);
    check(compare_complete_flags_o, 4'h0);
    send(1'b0, 32'h0000_12A5, 32'h3C00_0032);
    check(compare_complete_flags_o, 4'h5);
    check({3'h0, arm_signal_one_o}, 4'h1);
    check({3'h0, arm_signal_two_o}, 4'h0);
    check(channel_arm_o, 4'h5);
    $display("test first match done");
    send(1'b0, 32'h0000_00A5, 32'h3C00_0000);
    wait_cycles(10);
    check(compare_complete_flags_o, 4'h5);
    check({3'h0, arm_signal_one_o}, 4'h1);
    @(posedge clock_i);
    compare_complete_clear_i <= 4'hF;
    @(posedge clock_i);
    compare_complete_clear_i <= 4'h0;
    wait_cycles(2);
    check(compare_complete_flags_o, 4'h0);
    $display("test repeat and clear done");
    @(posedge clock_i);
    safing_state_i <= 1'b0;
    wait_cycles(3);
    check({3'h0, arm_signal_one_o}, 4'h1);
    wait_cycles(30);
    check({3'h0, arm_signal_one_o}, 4'h0);
    send(1'b0, 32'h0000_00A5, 32'h3C00_0032);
    check(compare_complete_flags_o, 4'h0);
    $display("test dwell and state gate done");
    @(posedge clock_i);
    safing_fsm_reset_i <= 1'b1;
    @(posedge clock_i);
    safing_fsm_reset_i <= 1'b0;
    safing_state_i <= 1'b1;
    record_enable_i <= 4'hC;
    wait_cycles(20);
    check({3'h0, arm_signal_one_o}, 4'h0);
    send(1'b1, 32'h0000_0000, 32'h0000_0000);
    send(1'b0, 32'h0000_00A5, 32'h3C00_FFFF);
    check(compare_complete_flags_o, 4'hC);
    check({3'h0, arm_signal_one_o}, 4'h0);
    $display("test safing reset and sign done");
    @(posedge clock_i);
    safing_fsm_reset_i <= 1'b1;
    record_enable_i <= 4'hF;
    in_frame_i <= 4'hB;
    chip_select_i <= 4'h0;
    arm_select_i <= 4'hA;
    field_select_i <= 4'hA;
    combine_i <= 4'h3;
    limit_enable_i <= 4'h8;
    @(posedge clock_i);
    safing_fsm_reset_i <= 1'b0;
    send(1'b1, 32'h0000_0000, 32'h0000_0000);
    send(1'b0, 32'h0000_00A5, 32'h3C32_000C);
    check(compare_complete_flags_o, 4'hB);
    check({3'h0, arm_signal_one_o}, 4'h1);
    check({3'h0, arm_signal_two_o}, 4'h0);
    send(1'b0, 32'h0000_0000, 32'h3C00_0032);
    check(compare_complete_flags_o, 4'hF);
    $display("test combine, limit and out of frame done");
    @(posedge clock_i);
    compare_complete_clear_i <= 4'hF;
    response_mask_i[3] <= 32'h0000_0000;
    response_target_i[3] <= 32'h0000_0000;
    @(posedge clock_i);
    compare_complete_clear_i <= 4'h0;
    frame_bits = 16;
    send(1'b0, 32'h0000_00A5, 32'h0000_0064);
    check(compare_complete_flags_o, 4'h8);
    check({3'h0, arm_signal_two_o}, 4'h1);
    $display("test short frame done");
    stop_test();
  end
endmodule
